/* hdl/i2c_byte_reader.sv */
// i2c master that performs one random-address byte read per request toggle
// runs on the free-running link clock; request address held stable by the core
`default_nettype none
module i2c_byte_reader #(
  parameter int QUARTER = usb_ident_pkg::QUARTER_CYCLES
) (
  input  wire logic       link_clk_in,
  input  wire logic       core_rst_in,
  input  wire logic       req_tog_in,
  input  wire logic [7:0] addr_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe_out,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic            ack_tog_out,
  output logic [7:0]      data_out,
  output logic            nak_out
);
  typedef struct packed {
    usb_ident_pkg::link_state_type st;
    logic [1:0] ph;
    logic [7:0] tick;
    logic [3:0] bitn;
    logic [1:0] bsel;
    logic [7:0] data;
    logic       nak;
    logic       scl_low;
    logic       sda_low;
    logic       req_seen;
    logic       ack_tog;
  } link_regs_type;

  link_regs_type link_reg;
  link_regs_type link_next;
  logic [2:0]    sync_q;
  logic [7:0]    cur_byte;

  // reset, request toggle and data pin all cross from outside
  sync_2ff #(.WIDTH(3)) u_sync (
    .clk_in (link_clk_in),
    .d_in   ({core_rst_in, req_tog_in, sda_in}),
    .q_out  (sync_q)
  );

  always_comb begin
    link_next = link_reg;
    unique case (link_reg.bsel)
      2'h0:    cur_byte = usb_ident_pkg::EE_DEV_WRITE;
      2'h1:    cur_byte = addr_in;
      default: cur_byte = usb_ident_pkg::EE_DEV_READ;
    endcase
    if (link_reg.tick != 8'h00) begin
      link_next.tick = link_reg.tick - 8'h01;
    end
    if (link_reg.st == usb_ident_pkg::LINK_IDLE) begin
      link_next.scl_low = 1'b0;
      link_next.sda_low = 1'b0;
      if (sync_q[1] != link_reg.req_seen) begin
        link_next.req_seen = sync_q[1];
        link_next.st       = usb_ident_pkg::LINK_START;
        link_next.ph       = 2'h0;
        link_next.tick     = 8'(QUARTER - 1);
        link_next.nak      = 1'b0;
        link_next.bsel     = 2'h0;
        link_next.bitn     = 4'h0;
      end
    end else if (link_reg.tick == 8'h00) begin
      // each bit is four quarters: set data, raise clock, sample, lower clock
      link_next.tick = 8'(QUARTER - 1);
      link_next.ph   = link_reg.ph + 2'h1;
      unique case (link_reg.st)
        usb_ident_pkg::LINK_START: begin
          if (link_reg.ph == 2'h0) link_next.sda_low = 1'b1;
          if (link_reg.ph == 2'h1) link_next.scl_low = 1'b1;
          if (link_reg.ph == 2'h3) link_next.st = usb_ident_pkg::LINK_WBYTE;
        end
        usb_ident_pkg::LINK_RSTART: begin
          if (link_reg.ph == 2'h0) link_next.sda_low = 1'b0;
          if (link_reg.ph == 2'h1) link_next.scl_low = 1'b0;
          if (link_reg.ph == 2'h2) link_next.sda_low = 1'b1;
          if (link_reg.ph == 2'h3) begin
            link_next.scl_low = 1'b1;
            link_next.st      = usb_ident_pkg::LINK_WBYTE;
          end
        end
        usb_ident_pkg::LINK_STOP: begin
          if (link_reg.ph == 2'h0) link_next.sda_low = 1'b1;
          if (link_reg.ph == 2'h1) link_next.scl_low = 1'b0;
          if (link_reg.ph == 2'h2) link_next.sda_low = 1'b0;
          if (link_reg.ph == 2'h3) begin
            link_next.st      = usb_ident_pkg::LINK_IDLE;
            link_next.ack_tog = ~link_reg.ack_tog;
          end
        end
        default: begin
          // byte phases: write bytes then one read byte closed by a nack
          if (link_reg.ph == 2'h0) begin
            link_next.sda_low = (link_reg.st == usb_ident_pkg::LINK_WBYTE) && (link_reg.bitn < 4'h8)
                                && !cur_byte[3'(4'h7 - link_reg.bitn)];
          end
          if (link_reg.ph == 2'h1) link_next.scl_low = 1'b0;
          if (link_reg.ph == 2'h2) begin
            if (link_reg.st == usb_ident_pkg::LINK_RBYTE && link_reg.bitn < 4'h8) begin
              link_next.data = {link_reg.data[6:0], sync_q[0]};
            end
            if (link_reg.st == usb_ident_pkg::LINK_WBYTE && link_reg.bitn == 4'h8 && sync_q[0]) begin
              link_next.nak = 1'b1;
            end
          end
          if (link_reg.ph == 2'h3) begin
            link_next.scl_low = 1'b1;
            link_next.bitn    = link_reg.bitn + 4'h1;
            if (link_reg.bitn == 4'h8) begin
              link_next.bitn = 4'h0;
              if (link_reg.st == usb_ident_pkg::LINK_RBYTE || link_reg.nak) begin
                link_next.st = usb_ident_pkg::LINK_STOP;
              end else if (link_reg.bsel == 2'h0) begin
                link_next.bsel = 2'h1;
              end else if (link_reg.bsel == 2'h1) begin
                link_next.bsel = 2'h2;
                link_next.st   = usb_ident_pkg::LINK_RSTART;
              end else begin
                link_next.st = usb_ident_pkg::LINK_RBYTE;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_in) begin
    if (sync_q[2]) begin
      link_reg <= '0;
    end else begin
      link_reg <= link_next;
    end
  end

  // open drain: only ever pull low
  assign scl_out     = 1'b0;
  assign sda_out     = 1'b0;
  assign scl_oe_out  = link_reg.scl_low;
  assign sda_oe_out  = link_reg.sda_low;
  assign ack_tog_out = link_reg.ack_tog;
  assign data_out    = link_reg.data;
  assign nak_out     = link_reg.nak;
endmodule
`default_nettype wire

/* hdl/sync_2ff.sv */
// two-flop synchroniser for levels and toggles
// assumes its input is quasi-static or a toggle; no reset, data path only
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [1:0][WIDTH-1:0] stage_reg;

  // first stage is read only by the second
  always_ff @(posedge clk_in) begin
    stage_reg <= {stage_reg[0], d_in};
  end

  assign q_out = stage_reg[1];
endmodule
`default_nettype wire

/* hdl/usb_ident_pkg.sv */
// shared constants and types of the usb identity loader
// assumes a 250 MHz core clock and a 160 ns link clock for the eeprom side
`default_nettype none
package usb_ident_pkg;
  // eeprom header layout
  localparam logic [7:0]  SIG0_VALUE      = 8'hED;
  localparam logic [7:0]  SIG1_VALUE      = 8'h15;
  localparam logic [3:0]  ADDR_SIG0       = 4'h0;
  localparam logic [3:0]  ADDR_SIG1       = 4'h1;
  localparam logic [3:0]  ADDR_POWER      = 4'h3;
  localparam logic [3:0]  ADDR_VID_LOW    = 4'h4;
  localparam logic [3:0]  ADDR_VID_HIGH   = 4'h5;
  localparam logic [3:0]  ADDR_PID_LOW    = 4'h6;
  localparam logic [3:0]  ADDR_PID_HIGH   = 4'h7;
  localparam logic [3:0]  ADDR_STR_MANU   = 4'h8;
  localparam logic [3:0]  ADDR_STR_PROD   = 4'h9;
  localparam logic [3:0]  ADDR_STR_INTF   = 4'hA;
  localparam logic [3:0]  ADDR_LAST_SUMMED = 4'hC;
  localparam logic [3:0]  ADDR_SUM        = 4'hD;
  localparam logic [1:0]  STR_COUNT       = 2'h3;
  localparam int          EE_BYTES        = 256;
  localparam logic [7:0]  EE_DEV_WRITE    = 8'hA0;
  localparam logic [7:0]  EE_DEV_READ     = 8'hA1;
  // boot source and strap fields
  localparam logic [1:0]  SEL_EEPROM      = 2'h0;
  localparam int          STRAP_NIB_LSB   = 0;
  localparam int          STRAP_BASE_LSB  = 4;
  localparam int          STRAP_PWR_LSB   = 6;
  localparam logic [15:0] STRAP_VID       = 16'h0553;
  localparam logic [11:0] STRAP_PID_BASE  = 12'h014;
  localparam logic [3:0][9:0] STRAP_MA    = {10'h1F4, 10'h15E, 10'h0FA, 10'h062};
  // timing
  localparam int          LINK_PERIOD_NS  = 160;
  localparam int          I2C_QUARTER_NS  = 2500;
  localparam int          QUARTER_CYCLES  = (I2C_QUARTER_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [1:0]  SETTLE_LAST     = 2'h3;
  // apb map
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_IDS         = 8'h08;
  localparam logic [7:0]  OFS_POWER       = 8'h0C;
  localparam logic [7:0]  OFS_STR_OFFSET  = 8'h10;
  localparam logic [7:0]  OFS_STR_LENGTH  = 8'h14;
  localparam logic [7:0]  OFS_BYTE_ADDR   = 8'h18;
  localparam logic [7:0]  OFS_BYTE_DATA   = 8'h1C;
  localparam int          CTRL_FORCE_BIT  = 0;
  localparam int          CTRL_RELOAD_BIT = 1;

  typedef enum logic [3:0] {
    BOOT_SETTLE, BOOT_DECIDE, BOOT_HDR_WAIT, BOOT_CHECK, BOOT_LEN_NEXT,
    BOOT_LEN_WAIT, BOOT_STRAP, BOOT_READY, BOOT_USER_WAIT
  } boot_state_type;

  typedef enum logic [2:0] {
    LINK_IDLE, LINK_START, LINK_WBYTE, LINK_RSTART, LINK_RBYTE, LINK_STOP
  } link_state_type;

  typedef struct packed {
    logic [15:0]     vid;
    logic [15:0]     pid;
    logic [7:0]      power_units;
    logic [2:0][7:0] str_offset;
    logic [2:0][7:0] str_length;
  } ident_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;
endpackage
`default_nettype wire

/* hdl/usb_identity_config_loader.sv */
// start-up loader for the usb identity: eeprom over i2c, or strap pins
// assumes an apb master on clk_in and a free-running link clock for the i2c side
//
// The address map and the APB interface to the registers are this design's own decisions.
`default_nettype none
module usb_identity_config_loader #(
  parameter int QUARTER = usb_ident_pkg::QUARTER_CYCLES
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       link_clk_in,
  input  wire logic [1:0]                 boot_source_select_in,
  input  wire logic [7:0]                 strap_in,
  input  wire usb_ident_pkg::apb_req_type apb_in,
  output logic      [31:0]                prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out,
  output logic                            scl_out,
  output logic                            scl_oe_out,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe_out,
  output usb_ident_pkg::ident_type        ident_out,
  output logic                            ident_valid_out
);
  typedef struct packed {
    usb_ident_pkg::boot_state_type st;
    logic [1:0]               settle;
    logic [3:0]               idx;
    logic [7:0]               sum;
    logic                     req_tog;
    logic                     ack_seen;
    logic [7:0]               addr;
    usb_ident_pkg::ident_type id;
    logic                     done;
    logic                     from_ee;
    logic                     sig_err;
    logic                     sum_err;
    logic                     nak_err;
    logic                     force_strap;
    logic [7:0]               rd_data;
    logic                     rd_valid;
    logic                     rd_nak;
    logic [31:0]              prdata;
    logic                     pslverr;
  } core_regs_type;

  core_regs_type core_reg;
  core_regs_type core_next;
  logic [10:0]   pin_q;
  logic          link_ack_tog;
  logic [7:0]    link_data;
  logic          link_nak;
  logic          ack_ev;
  logic [1:0]    sel;
  logic [7:0]    strap;
  logic [1:0]    pwr_sel;
  logic          ee_busy;

  // pins and the answer toggle all come from other domains
  sync_2ff #(.WIDTH(11)) u_pin_sync (
    .clk_in (clk_in),
    .d_in   ({link_ack_tog, boot_source_select_in, strap_in}),
    .q_out  (pin_q)
  );

  i2c_byte_reader #(.QUARTER(QUARTER)) u_reader (
    .link_clk_in (link_clk_in),
    .core_rst_in (rst_in),
    .req_tog_in  (core_reg.req_tog),
    .addr_in     (core_reg.addr),
    .sda_in      (sda_in),
    .scl_out     (scl_out),
    .scl_oe_out  (scl_oe_out),
    .sda_out     (sda_out),
    .sda_oe_out  (sda_oe_out),
    .ack_tog_out (link_ack_tog),
    .data_out    (link_data),
    .nak_out     (link_nak)
  );

  assign sel     = pin_q[9:8];
  assign strap   = pin_q[7:0];
  assign pwr_sel = strap[usb_ident_pkg::STRAP_PWR_LSB +: 2];
  assign ack_ev  = pin_q[10] != core_reg.ack_seen;
  assign ee_busy = core_reg.st != usb_ident_pkg::BOOT_READY;

  always_comb begin
    core_next = core_reg;
    // link data is stable by the time its toggle has crossed
    if (ack_ev) begin
      core_next.ack_seen = pin_q[10];
    end
    unique case (core_reg.st)
      usb_ident_pkg::BOOT_SETTLE: begin
        core_next.settle = core_reg.settle + 2'h1;
        if (core_reg.settle == usb_ident_pkg::SETTLE_LAST) begin
          core_next.st = usb_ident_pkg::BOOT_DECIDE;
        end
      end
      usb_ident_pkg::BOOT_DECIDE: begin
        core_next.sig_err = 1'b0;
        core_next.sum_err = 1'b0;
        core_next.nak_err = 1'b0;
        if (sel == usb_ident_pkg::SEL_EEPROM && !core_reg.force_strap) begin
          core_next.idx     = usb_ident_pkg::ADDR_SIG0;
          core_next.addr    = 8'(usb_ident_pkg::ADDR_SIG0);
          core_next.sum     = 8'h00;
          core_next.req_tog = ~core_reg.req_tog;
          core_next.st      = usb_ident_pkg::BOOT_HDR_WAIT;
        end else begin
          core_next.st = usb_ident_pkg::BOOT_STRAP;
        end
      end
      usb_ident_pkg::BOOT_HDR_WAIT: begin
        if (ack_ev && link_nak) begin
          core_next.nak_err = 1'b1;
          core_next.st      = usb_ident_pkg::BOOT_STRAP;
        end else if (ack_ev) begin
          if (core_reg.idx <= usb_ident_pkg::ADDR_LAST_SUMMED) begin
            core_next.sum = core_reg.sum + link_data;
          end
          case (core_reg.idx)
            usb_ident_pkg::ADDR_SIG0:     core_next.sig_err = link_data != usb_ident_pkg::SIG0_VALUE;
            usb_ident_pkg::ADDR_SIG1:     core_next.sig_err = core_reg.sig_err
                                                              || link_data != usb_ident_pkg::SIG1_VALUE;
            usb_ident_pkg::ADDR_POWER:    core_next.id.power_units = link_data;
            usb_ident_pkg::ADDR_VID_LOW:  core_next.id.vid[7:0] = link_data;
            usb_ident_pkg::ADDR_VID_HIGH: core_next.id.vid[15:8] = link_data;
            usb_ident_pkg::ADDR_PID_LOW:  core_next.id.pid[7:0] = link_data;
            usb_ident_pkg::ADDR_PID_HIGH: core_next.id.pid[15:8] = link_data;
            usb_ident_pkg::ADDR_STR_MANU: core_next.id.str_offset[0] = link_data;
            usb_ident_pkg::ADDR_STR_PROD: core_next.id.str_offset[1] = link_data;
            usb_ident_pkg::ADDR_STR_INTF: core_next.id.str_offset[2] = link_data;
            usb_ident_pkg::ADDR_SUM:      core_next.sum_err = link_data != core_reg.sum;
            default:                      core_next.sum_err = core_reg.sum_err;
          endcase
          if (core_reg.idx == usb_ident_pkg::ADDR_SUM) begin
            core_next.st = usb_ident_pkg::BOOT_CHECK;
          end else begin
            core_next.idx     = core_reg.idx + 4'h1;
            core_next.addr    = 8'(core_reg.idx + 4'h1);
            core_next.req_tog = ~core_reg.req_tog;
          end
        end
      end
      usb_ident_pkg::BOOT_CHECK: begin
        core_next.idx = 4'h0;
        if (core_reg.sig_err || core_reg.sum_err) begin
          core_next.st = usb_ident_pkg::BOOT_STRAP;
        end else begin
          core_next.st = usb_ident_pkg::BOOT_LEN_NEXT;
        end
      end
      usb_ident_pkg::BOOT_LEN_NEXT: begin
        if (core_reg.idx[1:0] == usb_ident_pkg::STR_COUNT) begin
          core_next.done    = 1'b1;
          core_next.from_ee = 1'b1;
          core_next.st      = usb_ident_pkg::BOOT_READY;
        end else if (core_reg.id.str_offset[core_reg.idx[1:0]] == 8'h00 ||
                     32'(core_reg.id.str_offset[core_reg.idx[1:0]]) >= 32'(usb_ident_pkg::EE_BYTES)) begin
          // absent string has no count to fetch
          core_next.id.str_length[core_reg.idx[1:0]] = 8'h00;
          core_next.idx = core_reg.idx + 4'h1;
        end else begin
          core_next.addr    = core_reg.id.str_offset[core_reg.idx[1:0]];
          core_next.req_tog = ~core_reg.req_tog;
          core_next.st      = usb_ident_pkg::BOOT_LEN_WAIT;
        end
      end
      usb_ident_pkg::BOOT_LEN_WAIT: begin
        if (ack_ev) begin
          // first byte of a block is its character count
          core_next.id.str_length[core_reg.idx[1:0]] = link_nak ? 8'h00 : link_data;
          core_next.nak_err = core_reg.nak_err || link_nak;
          core_next.idx     = core_reg.idx + 4'h1;
          core_next.st      = usb_ident_pkg::BOOT_LEN_NEXT;
        end
      end
      usb_ident_pkg::BOOT_STRAP: begin
        core_next.id.vid = usb_ident_pkg::STRAP_VID;
        core_next.id.pid = {usb_ident_pkg::STRAP_PID_BASE + 12'(strap[usb_ident_pkg::STRAP_BASE_LSB +: 2]),
                            strap[usb_ident_pkg::STRAP_NIB_LSB +: 4]};
        core_next.id.power_units = 8'(usb_ident_pkg::STRAP_MA[pwr_sel] >> 1);
        core_next.id.str_offset  = '0;
        core_next.id.str_length  = '0;
        core_next.from_ee        = 1'b0;
        core_next.done           = 1'b1;
        core_next.st             = usb_ident_pkg::BOOT_READY;
      end
      usb_ident_pkg::BOOT_USER_WAIT: begin
        // software fetches string characters one byte at a time
        if (ack_ev) begin
          core_next.rd_data  = link_data;
          core_next.rd_nak   = link_nak;
          core_next.rd_valid = 1'b1;
          core_next.st       = usb_ident_pkg::BOOT_READY;
        end
      end
      default: begin
        core_next.st = usb_ident_pkg::BOOT_READY;
      end
    endcase

    // apb setup phase latches read data so the access phase has zero waits
    if (apb_in.psel && !apb_in.penable) begin
      core_next.pslverr = 1'b0;
      unique case (apb_in.paddr)
        usb_ident_pkg::OFS_CTRL:       core_next.prdata = {31'h0, core_reg.force_strap};
        usb_ident_pkg::OFS_STATUS:     core_next.prdata = {22'h0, sel, 2'h0, core_reg.nak_err, core_reg.sum_err,
                                                           core_reg.sig_err, core_reg.from_ee, ee_busy, core_reg.done};
        usb_ident_pkg::OFS_IDS:        core_next.prdata = {core_reg.id.pid, core_reg.id.vid};
        usb_ident_pkg::OFS_POWER:      core_next.prdata = {24'h0, core_reg.id.power_units};
        usb_ident_pkg::OFS_STR_OFFSET: core_next.prdata = {8'h00, core_reg.id.str_offset};
        usb_ident_pkg::OFS_STR_LENGTH: core_next.prdata = {8'h00, core_reg.id.str_length};
        usb_ident_pkg::OFS_BYTE_ADDR:  core_next.prdata = {24'h0, core_reg.addr};
        usb_ident_pkg::OFS_BYTE_DATA:  core_next.prdata = {22'h0, core_reg.rd_nak, core_reg.rd_valid,
                                                           core_reg.rd_data};
        default: begin
          core_next.prdata  = 32'h0;
          core_next.pslverr = 1'b1;
        end
      endcase
    end

    // writes land on the access edge; busy loader ignores reload and fetch
    if (apb_in.psel && apb_in.penable && apb_in.pwrite) begin
      if (apb_in.paddr == usb_ident_pkg::OFS_CTRL) begin
        core_next.force_strap = apb_in.pwdata[usb_ident_pkg::CTRL_FORCE_BIT];
        if (apb_in.pwdata[usb_ident_pkg::CTRL_RELOAD_BIT] && !ee_busy) begin
          core_next.done   = 1'b0;
          core_next.settle = 2'h0;
          core_next.st     = usb_ident_pkg::BOOT_SETTLE;
        end
      end else if (apb_in.paddr == usb_ident_pkg::OFS_BYTE_ADDR && !ee_busy) begin
        core_next.addr     = apb_in.pwdata[7:0];
        core_next.req_tog  = ~core_reg.req_tog;
        core_next.rd_valid = 1'b0;
        core_next.st       = usb_ident_pkg::BOOT_USER_WAIT;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      core_reg <= '0;
    end else begin
      core_reg <= core_next;
    end
  end

  assign pready_out      = 1'b1;
  assign prdata_out      = core_reg.prdata;
  assign pslverr_out     = core_reg.pslverr;
  assign ident_out       = core_reg.id;
  assign ident_valid_out = core_reg.done;
endmodule
`default_nettype wire

/* tb/eeprom_model.sv */
// eeprom partner: i2c slave, one address byte, 256 bytes
// assumes the bench resolves both lines with pull-ups
`default_nettype none
module eeprom_model (
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic nak_in,
  output logic      low_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] sh, ptr, dat;
  int         n = 0;
  int         ph = 0;
  initial low_out = 1'b0;
  always @(negedge sda_in) if (scl_in) begin
    n = 0;
    ph = 0;
  end
  always @(posedge scl_in) begin
    sh = {sh[6:0], sda_in};
    n++;
  end
  always @(negedge scl_in) begin
    if (n == 8 && ph < 2) begin
      low_out = !nak_in;  // refuses only when told to
      ptr = (ph == 1) ? sh : ptr;
      ph = (ph == 0 && sh[0]) ? 3 : ph + 1;
    end else if (n == 9) begin
      n = 0;
      dat = mem[ptr];
      low_out = (ph == 3) ? !dat[7] : 1'b0;
      ptr = ptr + 8'(ph == 3);
      ph = (ph == 3) ? 4 : ph;
    end else if (ph == 4) begin
      low_out = (n < 8) ? !dat[7-n] : 1'b0;
    end
  end
endmodule
`default_nettype wire

/* tb/loader_properties.sv */
// checker: reset, strap decode and hold relations of the loader
// assumes straps stay put while a boot runs
`default_nettype none
module loader_checker (
  input wire logic                     clk_in,
  input wire logic                     rst_in,
  input wire logic [1:0]               boot_source_select_in,
  input wire logic [7:0]               strap_in,
  input wire logic                     pready_out,
  input wire usb_ident_pkg::ident_type ident_out,
  input wire logic                     ident_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire logic sb = boot_source_select_in != 2'h0;
  AST_CLEAR: assert property ($fell(rst_in) |-> !ident_valid_out && ident_out == '0)
    else $error("identity not cleared");
  AST_WAIT: assert property ($fell(rst_in) |-> !ident_valid_out [*4])
    else $error("identity valid too soon");
  AST_POWER: assert property ($rose(ident_valid_out) && sb |-> ident_out.power_units ==
    (strap_in[7] ? (strap_in[6] ? 8'hFA : 8'hAF) : (strap_in[6] ? 8'h7D : 8'h31))) else $error("strap power");
  AST_NIBBLE: assert property ($rose(ident_valid_out) && sb |-> ident_out.pid[3:0] == strap_in[3:0])
    else $error("strap nibble");
  AST_BASE: assert property ($rose(ident_valid_out) && sb |-> ident_out.vid == 16'h0553 &&
    ident_out.pid[15:4] == 12'h014 + 12'(strap_in[5:4])) else $error("strap base");
  AST_ABSENT: assert property (ident_valid_out && ident_out.str_offset[1] == 8'h00 |->
    ident_out.str_length[1] == 8'h00) else $error("absent string has length");
  AST_HOLD: assert property (ident_valid_out && $past(ident_valid_out) |-> $stable(ident_out))
    else $error("identity moved while valid");
  AST_READY: assert property (pready_out)
    else $error("wait state seen");
endmodule
bind usb_identity_config_loader loader_checker chk_i (.clk_in, .rst_in, .boot_source_select_in,
  .strap_in, .pready_out, .ident_out, .ident_valid_out);
`default_nettype wire

/* tb/tb_top.sv */
// bench: strap and eeprom boots of the loader, checked over apb
// assumes eeprom_model on the i2c lines and the bound checker
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       clk_in = 1'b0;
  logic                       lclk = 1'b0;
  logic                       rst_in = 1'b1;
  logic [1:0]                 sel = 2'h1;
  logic [7:0]                 strap = 8'hE9;
  logic                       nak = 1'b0;
  usb_ident_pkg::apb_req_type apb = '0;
  logic [31:0]                rdata, q;
  logic                       rdy, err, e, scl_oe, sda_oe, low;
  logic [31:0]                pw [3] = '{32'h31, 32'h7D, 32'hAF};
  int                         bad_count = 0;
  int                         num_checks = 0;
  int                         cyc = 0;
  wire logic                  scl = !scl_oe;
  wire logic                  sda = !(sda_oe || low);
  always #2 clk_in = !clk_in;
  initial #1.3 forever #80 lclk = !lclk;
  // one link cycle per quarter keeps sixteen byte reads inside the cycle budget
  usb_identity_config_loader #(.QUARTER(1)) uut (.clk_in, .rst_in, .link_clk_in(lclk),
    .boot_source_select_in(sel), .strap_in(strap), .apb_in(apb), .prdata_out(rdata), .pready_out(rdy),
    .pslverr_out(err), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe),
    .ident_out(), .ident_valid_out());
  eeprom_model ee (.scl_in(scl), .sda_in(sda), .nak_in(nak), .low_out(low));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in) apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_in) apb.penable <= 1'b1;
    do @(posedge clk_in); while (rdy !== 1'b1);
    q = rdata;
    e = err;
    apb <= '0;
  endtask
  task automatic chk(input logic [31:0] x, input logic [31:0] s, input string n);
    num_checks++;
    if (s !== x) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    do bus(1'b0, a, '0); while (q[b+:2] !== 2'b01);
  endtask
  task automatic boot(input logic [1:0] s);
    @(posedge clk_in);
    sel <= s;
    rst_in <= 1'b1;
    repeat (100) @(posedge clk_in);  // long, so the link side sees it too
    rst_in <= 1'b0;
    poll(8'h04, 0);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 110000) begin
      bad_count++;
      stop_test;
    end
  end
  initial begin
    for (int i = 0; i < 256; i++) ee.mem[i] = 8'h00;
    {ee.mem[0], ee.mem[1], ee.mem[3], ee.mem[16], ee.mem[17]} = {40'hED15C80548};
    {ee.mem[4], ee.mem[5], ee.mem[6], ee.mem[7], ee.mem[8]} = {40'h3412785610};
    for (int i = 0; i < 13; i++) ee.mem[13] += ee.mem[i];
    boot(2'h1);
    bus(1'b0, 8'h0C, '0);
    chk(32'hFA, q, "power");
    bus(1'b0, 8'h08, '0);
    chk(32'h01690553, q, "ids");
    bus(1'b0, 8'h40, '0);
    chk(32'h0, q, "unmapped");
    chk(32'h1, 32'(e), "slverr");
    for (int k = 0; k < 3; k++) begin
      strap <= {k[1:0], k[1:0], 4'h6};
      bus(1'b1, 8'h00, 32'h3);
      poll(8'h04, 0);
      bus(1'b0, 8'h0C, '0);
      chk(pw[k], q, "power");
      bus(1'b0, 8'h08, '0);
      chk({12'h014 + 12'(k), 20'h60553}, q, "ids");
    end
    boot(2'h0);
    bus(1'b0, 8'h08, '0);
    chk(32'h56781234, q, "ids");
    bus(1'b0, 8'h0C, '0);
    chk(32'hC8, q, "power");
    bus(1'b0, 8'h10, '0);
    chk(32'h10, q, "offsets");
    bus(1'b0, 8'h14, '0);
    chk(32'h5, q, "lengths");
    nak <= 1'b1;
    bus(1'b1, 8'h00, 32'h2);
    poll(8'h04, 0);
    chk(32'h20, q & 32'h24, "fallback");
    bus(1'b0, 8'h08, '0);
    chk(32'h01660553, q, "ids");
    nak <= 1'b0;
    bus(1'b1, 8'h18, 32'h11);
    poll(8'h1C, 8);
    chk(32'h148, q, "byte");
    stop_test;
  end
endmodule
`default_nettype wire
